// File: spt_pkg.sv
/*
  Shared constants for the protocol timing supervisor: documented times in
  their own units, cycle counts derived from them, and timer slot indexes.
  Assumes a single 40 MHz protocol-layer clock.
*/
package spt_pkg;

  // clock period of the protocol layer logic
  localparam longint CLK_PERIOD_PS = 25000;

  // documented times, figures as printed
  localparam longint PORT_CFG_US         = 20;      // port config exchange max
  localparam longint PING_REPLY_NS       = 250;     // ping reply max
  localparam longint NOT_READY_NS        = 250;     // nrdy reply max
  localparam longint DATA_REPLY_NS       = 250;     // dp reply max
  localparam longint DEV_ACK_NS          = 250;     // ack reply max
  localparam longint BURST_GAP_NS        = 100;     // gap between burst dps max
  localparam longint PING_HOLD_SI        = 2;       // service intervals, min
  localparam longint SERVICE_INTERVAL_NS = 125000;  // largest iso interval
  localparam longint READY_HOLD_MS       = 500;     // unserviced erdy holdoff min
  localparam longint WAKE_REPEAT_MS      = 2500;    // wake notice spacing min
  localparam longint LTM_WINDOW_MS       = 1;       // two messages per window
  localparam longint LTM_NOTICE_US       = 10;      // notice after enable change

  // latency tolerance values in microseconds
  localparam logic [15:0] LTM_DEFAULT_US = 16'h03E8;  // 1 ms default
  localparam logic [15:0] LTM_FLOOR_US   = 16'h007D;  // 125 us floor

  // timestamp unit is 8 hs bit times; interval adjust step is that / 4096
  localparam real    HS_BIT_PS          = 1.0e6 / 480.0;
  localparam real    TS_UNIT_HS_BITS    = 8.0;
  localparam real    ADJ_DIVISOR        = 4096.0;
  localparam real    ADJ_STEP_PS        = TS_UNIT_HS_BITS * HS_BIT_PS / ADJ_DIVISOR;

  // longest time: round down, never below one cycle
  function automatic int unsigned cyc_max(input longint ns);
    longint c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  // least time: round up, never below one cycle
  function automatic int unsigned cyc_min(input longint ns);
    longint c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  // derived cycle counts (short ones; long ones are top parameters)
  localparam int unsigned PORT_CFG_CYC   = cyc_max(PORT_CFG_US * 1000);
  localparam int unsigned PING_REPLY_CYC = cyc_max(PING_REPLY_NS);
  localparam int unsigned ATP_REPLY_CYC  = cyc_max((NOT_READY_NS < DATA_REPLY_NS) ?
                                                   NOT_READY_NS : DATA_REPLY_NS);
  localparam int unsigned DPP_REPLY_CYC  = cyc_max((NOT_READY_NS < DEV_ACK_NS) ?
                                                   NOT_READY_NS : DEV_ACK_NS);
  localparam int unsigned BURST_GAP_CYC  = cyc_max(BURST_GAP_NS);
  localparam int unsigned LTM_NOTICE_CYC = cyc_max(LTM_NOTICE_US * 1000);

  // timer slot indexes
  localparam int T_CFG   = 0;   // port configuration deadline
  localparam int T_PING  = 1;   // ping reply deadline
  localparam int T_ATP   = 2;   // ack tp reply deadline
  localparam int T_DPP   = 3;   // data payload reply deadline
  localparam int T_GAP   = 4;   // burst gap limit
  localparam int T_PHOLD = 5;   // low power holdoff after ping
  localparam int T_EHOLD = 6;   // low power holdoff after erdy
  localparam int T_WAKE  = 7;   // wake notice repeat
  localparam int T_LTM0  = 8;   // latency message window slot 0
  localparam int T_LTM1  = 9;   // latency message window slot 1
  localparam int T_LTMN  = 10;  // latency notice deadline
  localparam int NT      = 11;

endpackage

// File: spt_timer.sv
/*
  One interval timer: restarts on start, halts on stop, reports done once
  LIMIT cycles have passed since the start edge.
  Assumes one-cycle start and stop strobes on sys_clk.
*/
`timescale 1ns/1ps
module spt_timer #(
  parameter int unsigned LIMIT = 1
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic stop,
  output logic      running,
  output logic      done
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM_W = LIMIT[W-1:0];

  logic         run_reg;  // timer armed
  logic [W-1:0] cnt_reg;  // cycles since start, saturates at limit

  // a zero limit could never be measured
  if (LIMIT < 1) begin : g_bad_limit
    $error("spt_timer: LIMIT must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // arm / disarm; start wins over stop so a back-to-back event is kept
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_reg <= 1'b0;
    end else if (start) begin
      run_reg <= 1'b1;
    end else if (stop) begin
      run_reg <= 1'b0;
    end
  end

  // cycle counter, limit already rounded by the package
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= '0;
    end else if (run_reg && cnt_reg != LIM_W) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign running = run_reg;
  assign done    = run_reg && (cnt_reg == LIM_W);
endmodule

// File: spt_timing_top.sv
/*
  Device-side protocol timing supervisor: watches reply deadlines, burst
  gaps, low-power holdoffs, wake notice repeats and latency message limits.
  Assumes one-cycle event strobes from the protocol layer, all on sys_clk.
*/
`timescale 1ns/1ps
module spt_timing_top
  import spt_pkg::*;
#(
  parameter int unsigned PING_HOLD_CYC  = cyc_min(PING_HOLD_SI * SERVICE_INTERVAL_NS),
  parameter int unsigned READY_HOLD_CYC = cyc_min(READY_HOLD_MS * 1000000),
  parameter int unsigned WAKE_CYC       = cyc_min(WAKE_REPEAT_MS * 1000000),
  parameter int unsigned LTM_WIN_CYC    = cyc_min(LTM_WINDOW_MS * 1000000)
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        cfg_done,
  input  wire logic        ping_rx_end,
  input  wire logic        ping_reply_start,
  input  wire logic        ack_tp_rx_end,
  input  wire logic        dpp_rx_end,
  input  wire logic        nrdy_start,
  input  wire logic        dp_start,
  input  wire logic        ack_start,
  input  wire logic        tx_busy,
  input  wire logic        tx_dp_end,
  input  wire logic        tx_eob,
  input  wire logic        erdy_sent,
  input  wire logic        erdy_serviced,
  input  wire logic        wake_sent,
  input  wire logic        dev_accessed,
  input  wire logic        ltm_req_valid,
  input  wire logic [15:0] ltm_req_us,
  input  wire logic        ltm_sent,
  input  wire logic        ltm_en_change,
  output logic             cfg_late,
  output logic             ping_late,
  output logic             ack_tp_late,
  output logic             dpp_late,
  output logic             gap_late,
  output logic             lp_allowed,
  output logic             wake_resend,
  output logic [15:0]      ltm_value,
  output logic             ltm_send_ok,
  output logic             ltm_notice_req,
  output logic             ltm_notice_late
);
  // per-slot limits in cycles
  localparam int unsigned LIM [NT] = '{PORT_CFG_CYC, PING_REPLY_CYC, ATP_REPLY_CYC,
    DPP_REPLY_CYC, BURST_GAP_CYC, PING_HOLD_CYC, READY_HOLD_CYC, WAKE_CYC,
    LTM_WIN_CYC, LTM_WIN_CYC, LTM_NOTICE_CYC};

  logic [NT-1:0]     st;                 // timer starts
  logic [NT-1:0]     sp;                 // timer stops
  logic [NT-1:0]     run;                // timer armed
  logic [NT-1:0]     done;               // limit reached
  logic [NT-1:0]     done_d_reg;         // done one cycle ago
  logic [NT-1:0]     rise;               // limit just reached
  logic [NT-1:0]     hold;               // armed and not yet at limit
  logic [1:0]        free;               // latency window slots available
  logic [T_DPP:T_PING] busy_seen_reg;    // other traffic seen during a reply wait
  logic              boot_reg;           // low only in first cycle after reset
  logic              cfg_late_reg;
  logic              ping_late_reg;
  logic              ack_tp_late_reg;
  logic              dpp_late_reg;
  logic              gap_late_reg;
  logic              lp_allowed_reg;
  logic              wake_resend_reg;
  logic [15:0]       ltm_value_reg;
  logic              ltm_send_ok_reg;
  logic              ltm_notice_req_reg;
  logic              ltm_notice_late_reg;

  // the long holdoffs need at least one cycle each
  if (PING_HOLD_CYC < 1 || READY_HOLD_CYC < 1 || WAKE_CYC < 1 || LTM_WIN_CYC < 1)
  begin : g_bad_param
    $error("spt_timing_top: hold counts must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer starts and stops
  assign free[0] = !run[T_LTM0] || done[T_LTM0];
  assign free[1] = !run[T_LTM1] || done[T_LTM1];

  always_comb begin
    st = '0;
    sp = '0;
    st[T_CFG]   = !boot_reg;
    sp[T_CFG]   = cfg_done;
    st[T_PING]  = ping_rx_end;
    sp[T_PING]  = ping_reply_start;
    st[T_ATP]   = ack_tp_rx_end;
    sp[T_ATP]   = dp_start | nrdy_start;
    st[T_DPP]   = dpp_rx_end;
    sp[T_DPP]   = ack_start | nrdy_start;
    st[T_GAP]   = tx_dp_end & !tx_eob;
    sp[T_GAP]   = dp_start;
    st[T_PHOLD] = ping_rx_end;
    st[T_EHOLD] = erdy_sent;
    sp[T_EHOLD] = erdy_serviced;
    st[T_WAKE]  = wake_sent;
    sp[T_WAKE]  = dev_accessed;
    st[T_LTM0]  = ltm_sent & free[0];
    st[T_LTM1]  = ltm_sent & !free[0] & free[1];
    st[T_LTMN]  = ltm_en_change;
    sp[T_LTMN]  = ltm_sent;
  end

  // one timer per slot
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    spt_timer #(.LIMIT(LIM[g])) u_tmr (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (st[g]),
      .stop    (sp[g]),
      .running (run[g]),
      .done    (done[g])
    );
  end

  assign rise = done & ~done_d_reg;
  assign hold = run & ~done;

  ////////////////////////////////////////////////////////////////////////////
  // edge history and first-cycle marker
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done_d_reg <= '0;
      boot_reg   <= 1'b0;
    end else begin
      done_d_reg <= done;
      boot_reg   <= 1'b1;
    end
  end

  // pending traffic excuses a reply deadline
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_seen_reg <= '0;
    end else begin
      for (int i = T_PING; i <= T_DPP; i++) begin
        if (st[i]) begin
          busy_seen_reg[i] <= tx_busy;
        end else if (run[i] && tx_busy) begin
          busy_seen_reg[i] <= 1'b1;
        end
      end
    end
  end

  // deadline misses, one-cycle pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_late_reg    <= 1'b0;
      ping_late_reg   <= 1'b0;
      ack_tp_late_reg <= 1'b0;
      dpp_late_reg    <= 1'b0;
      gap_late_reg    <= 1'b0;
    end else begin
      cfg_late_reg    <= rise[T_CFG];
      ping_late_reg   <= rise[T_PING] & !(busy_seen_reg[T_PING] | tx_busy);
      ack_tp_late_reg <= rise[T_ATP] & !(busy_seen_reg[T_ATP] | tx_busy);
      dpp_late_reg    <= rise[T_DPP] & !(busy_seen_reg[T_DPP] | tx_busy);
      gap_late_reg    <= rise[T_GAP];
    end
  end

  // low power entry only after the ping holdoff has run out and the erdy holdoff has run out or been serviced
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lp_allowed_reg <= 1'b0;
    end else begin
      lp_allowed_reg <= !(hold[T_PHOLD] | hold[T_EHOLD]);
    end
  end

  // wake notice repeat; only a new wake_sent restarts the timer, not the resend
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_resend_reg <= 1'b0;
    end else begin
      wake_resend_reg <= rise[T_WAKE];
    end
  end

  // advertised tolerance: default at reset, clamped to the floor
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ltm_value_reg <= LTM_DEFAULT_US;
    end else if (ltm_req_valid) begin
      ltm_value_reg <= (ltm_req_us < LTM_FLOOR_US) ? LTM_FLOOR_US : ltm_req_us;
    end
  end

  // rate limit looks ahead past this cycle's send, so it never lags a send;
  // a slot just reaching its limit frees one cycle late, which is safe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ltm_send_ok_reg     <= 1'b0;
      ltm_notice_req_reg  <= 1'b0;
      ltm_notice_late_reg <= 1'b0;
    end else begin
      ltm_send_ok_reg     <= (free[0] & !st[T_LTM0]) | (free[1] & !st[T_LTM1]);
      ltm_notice_req_reg  <= hold[T_LTMN];
      ltm_notice_late_reg <= rise[T_LTMN];
    end
  end

  assign cfg_late        = cfg_late_reg;
  assign ping_late       = ping_late_reg;
  assign ack_tp_late     = ack_tp_late_reg;
  assign dpp_late        = dpp_late_reg;
  assign gap_late        = gap_late_reg;
  assign lp_allowed      = lp_allowed_reg;
  assign wake_resend     = wake_resend_reg;
  assign ltm_value       = ltm_value_reg;
  assign ltm_send_ok     = ltm_send_ok_reg;
  assign ltm_notice_req  = ltm_notice_req_reg;
  assign ltm_notice_late = ltm_notice_late_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cfg_late;
    @(posedge sys_clk) disable iff (!resetn) $rose(done[T_CFG]) |=> cfg_late_reg;
  endproperty
  a_cfg_late: assert property (p_cfg_late) else $error("config miss not flagged");

  property p_ping_hold;
    @(posedge sys_clk) disable iff (!resetn) ping_rx_end |-> ##2 !lp_allowed_reg;
  endproperty
  a_ping_hold: assert property (p_ping_hold) else $error("low power after ping");

  property p_ping_late;
    @(posedge sys_clk) disable iff (!resetn)
      ping_rx_end && !tx_busy ##1 (!ping_reply_start && !ping_rx_end && !tx_busy)[*8]
      ##1 (!ping_reply_start && !ping_rx_end && !tx_busy)[*2] |-> ##2 ping_late_reg;
  endproperty
  a_ping_late: assert property (p_ping_late) else $error("ping miss not flagged");

  property p_ltm_default;
    @(posedge sys_clk) disable iff (!resetn) !boot_reg |-> ltm_value_reg == LTM_DEFAULT_US;
  endproperty
  a_ltm_default: assert property (p_ltm_default) else $error("bad default");

  property p_ltm_floor;
    @(posedge sys_clk) disable iff (!resetn) ltm_value_reg >= LTM_FLOOR_US;
  endproperty
  a_ltm_floor: assert property (p_ltm_floor) else $error("tolerance below floor");

  property p_erdy_hold;
    @(posedge sys_clk) disable iff (!resetn)
      erdy_sent && !erdy_serviced |-> ##2 !lp_allowed_reg;
  endproperty
  a_erdy_hold: assert property (p_erdy_hold) else $error("low power after erdy");

  property p_wake;
    @(posedge sys_clk) disable iff (!resetn) $rose(done[T_WAKE]) |=> wake_resend_reg;
  endproperty
  a_wake: assert property (p_wake) else $error("wake resend missing");

  property p_gap;
    @(posedge sys_clk) disable iff (!resetn)
      tx_dp_end && !tx_eob ##1 (!dp_start && !tx_dp_end)[*4] |=> ##1 gap_late_reg;
  endproperty
  a_gap: assert property (p_gap) else $error("burst gap miss not flagged");

  property p_busy_excuse;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(done[T_PING]) && busy_seen_reg[T_PING] |=> !ping_late_reg;
  endproperty
  a_busy_excuse: assert property (p_busy_excuse) else $error("busy miss flagged");

  property p_ltm_rate;
    @(posedge sys_clk) disable iff (!resetn) !free[0] && !free[1] |=> !ltm_send_ok_reg;
  endproperty
  a_ltm_rate: assert property (p_ltm_rate) else $error("third message allowed");

  property p_ltm_notice;
    @(posedge sys_clk) disable iff (!resetn)
      ltm_en_change && !ltm_sent |-> ##2 ltm_notice_req_reg;
  endproperty
  a_ltm_notice: assert property (p_ltm_notice) else $error("notice not requested");
endmodule

// File: spt_reply_model.sv
/*
  Far-side reply model: answers a trigger strobe with a one-cycle reply
  strobe a set number of cycles later, like the transmit path would.
  Assumes strobes are sampled on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
module spt_reply_model (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       trig,
  input  wire logic [7:0] delay,
  output logic            reply
);
  logic [7:0] cnt_reg;  // cycles left until the reply

  ////////////////////////////////////////////////////////////////////////
  // load on trigger and count down; delay zero means never reply
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
    end else if (trig) begin
      cnt_reg <= delay;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // launched off the falling edge so the sampling edge never races it
  always_ff @(negedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reply <= 1'b0;
    end else begin
      reply <= (cnt_reg == 8'h01);
    end
  end
endmodule

// File: tb.sv
/*
  Self-checking bench for the timing supervisor: one task per scenario.
  Assumes the supervisor is built with short holdoff and window counts.
*/
`timescale 1ns/1ps
module tb;
  // short counts keep the run brief
  localparam int unsigned PH = 40, EH = 60, WK = 50, LW = 100;
  // stimulus strobe slots
  localparam int CFG = 0, PING = 1, ATP = 2, DPP = 3, NRDY = 4, TXE = 5, ERDY = 6;
  localparam int ESRV = 7, WAKE = 8, ACC = 9, LREQ = 10, LSNT = 11, LEN = 12, DPS = 13;
  // watched output slots
  localparam int F_CFG = 0, F_PING = 1, F_ATP = 2, F_DPP = 3, F_GAP = 4, F_LTL = 5;
  localparam int F_LP = 6, F_WAKE = 7, F_OK = 8, F_REQ = 9;

  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [13:0] st = '0;              // one-cycle strobes
  logic        tx_busy = 1'b0;
  logic        tx_eob = 1'b0;
  logic [15:0] ltm_req_us = 16'h0000;
  logic [7:0]  d_ping = 8'h00, d_atp = 8'h00, d_dpp = 8'h00;  // model delays
  logic        ping_rep, dp_rep, ack_rep;
  logic        cfg_late, ping_late, ack_tp_late, dpp_late, gap_late, lp_allowed;
  logic        wake_resend, ltm_send_ok, ltm_notice_req, ltm_notice_late;
  logic [15:0] ltm_value;
  logic [9:0]  flg;                  // outputs gathered for the wait tasks
  int          n_errors = 0;
  int          checks = 0;

  assign flg = {ltm_notice_req, ltm_send_ok, wake_resend, lp_allowed, ltm_notice_late,
                gap_late, dpp_late, ack_tp_late, ping_late, cfg_late};

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // design and far-side reply models
  spt_timing_top #(.PING_HOLD_CYC(PH), .READY_HOLD_CYC(EH), .WAKE_CYC(WK),
    .LTM_WIN_CYC(LW)) i_spt_timing_top (
    .sys_clk(sys_clk), .resetn(resetn), .cfg_done(st[CFG]), .ping_rx_end(st[PING]),
    .ping_reply_start(ping_rep), .ack_tp_rx_end(st[ATP]), .dpp_rx_end(st[DPP]),
    .nrdy_start(st[NRDY]), .dp_start(dp_rep | st[DPS]), .ack_start(ack_rep),
    .tx_busy(tx_busy), .tx_dp_end(st[TXE]), .tx_eob(tx_eob), .erdy_sent(st[ERDY]),
    .erdy_serviced(st[ESRV]), .wake_sent(st[WAKE]), .dev_accessed(st[ACC]),
    .ltm_req_valid(st[LREQ]), .ltm_req_us(ltm_req_us), .ltm_sent(st[LSNT]),
    .ltm_en_change(st[LEN]), .cfg_late(cfg_late), .ping_late(ping_late),
    .ack_tp_late(ack_tp_late), .dpp_late(dpp_late), .gap_late(gap_late),
    .lp_allowed(lp_allowed), .wake_resend(wake_resend), .ltm_value(ltm_value),
    .ltm_send_ok(ltm_send_ok), .ltm_notice_req(ltm_notice_req),
    .ltm_notice_late(ltm_notice_late));
  spt_reply_model i_spt_reply_model_ping (.sys_clk(sys_clk), .resetn(resetn),
    .trig(st[PING]), .delay(d_ping), .reply(ping_rep));
  spt_reply_model i_spt_reply_model_atp (.sys_clk(sys_clk), .resetn(resetn),
    .trig(st[ATP]), .delay(d_atp), .reply(dp_rep));
  spt_reply_model i_spt_reply_model_dpp (.sys_clk(sys_clk), .resetn(resetn),
    .trig(st[DPP]), .delay(d_dpp), .reply(ack_rep));
  // host-side duties have no logic in the block, and the stimulus does not
  // model them either: payload ack inside 3 us timestamp inside 8 us of a
  // boundary in 8 hs bit time units timestamps begun within
  // 250 us of U0 silent transaction failed after 10 us

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // count falling edges until a flag takes a level; bounded
  task automatic wait_flag(input string nm, input int i, input logic v, input int e);
    int n;
    n = 0;
    while (flg[i] !== v) begin
      @(negedge sys_clk);
      n++;
      if (n > e + 20) begin
        chk({nm, " wait"}, 16'(e), 16'(n));
        conclude();
      end
    end
    chk(nm, 16'(e), 16'(n));
  endtask

  // a flag must stay low for a number of cycles
  task automatic quiet(input string nm, input int i, input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      if (flg[i] !== 1'b0) hits++;  // an unknown flag counts as a hit
    end
    chk(nm, 16'h0000, 16'(hits));
  endtask

  // strobe held for exactly one rising edge
  task automatic fire(input int i);
    @(negedge sys_clk);
    st[i] = 1'b1;
    @(negedge sys_clk);
    st[i] = 1'b0;
  endtask

  // reset held 16 cycles, released at a falling edge
  task automatic do_reset();
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    do_reset();
    chk("lp before edge 0", 16'h0000, 16'(lp_allowed));
    wait_flag("cfg_late", F_CFG, 1'b1, 802);
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk("ltm_value in reset", 16'h03E8, ltm_value);
    chk("send_ok in reset", 16'h0000, 16'(ltm_send_ok));
    do_reset();
    wait_flag("lp rise", F_LP, 1'b1, 1);
    fire(CFG);
    quiet("cfg done in time", F_CFG, 820);
  endtask

  task automatic t_ping();
    d_ping = 8'h0A;
    fire(PING);
    quiet("ping reply at limit", F_PING, 20);
    d_ping = 8'h0B;
    fire(PING);
    wait_flag("ping_late", F_PING, 1'b1, 11);
    d_ping = 8'h00;
    tx_busy = 1'b1;
    fire(PING);
    quiet("ping busy excused", F_PING, 20);
    tx_busy = 1'b0;
  endtask

  task automatic t_reply();
    d_atp = 8'h0A;
    fire(ATP);
    quiet("dp reply at limit", F_ATP, 20);
    d_atp = 8'h00;
    fire(ATP);
    repeat (8) @(negedge sys_clk);
    fire(NRDY);
    quiet("nrdy to ack tp", F_ATP, 20);
    fire(ATP);
    wait_flag("ack_tp_late", F_ATP, 1'b1, 11);
    d_dpp = 8'h0A;
    fire(DPP);
    quiet("ack at limit", F_DPP, 20);
    d_dpp = 8'h0B;
    fire(DPP);
    wait_flag("dpp_late", F_DPP, 1'b1, 11);
    d_dpp = 8'h00;
    fire(DPP);
    repeat (8) @(negedge sys_clk);
    fire(NRDY);
    quiet("nrdy to payload", F_DPP, 20);
  endtask

  task automatic t_gap();
    fire(TXE);
    repeat (2) @(negedge sys_clk);
    fire(DPS);
    quiet("gap at limit", F_GAP, 10);
    fire(TXE);
    wait_flag("gap_late", F_GAP, 1'b1, 5);
    tx_eob = 1'b1;
    fire(TXE);
    tx_eob = 1'b0;
    quiet("gap after eob", F_GAP, 10);
  endtask

  task automatic t_lp();
    fire(PING);
    @(negedge sys_clk);
    chk("lp after ping", 16'h0000, 16'(lp_allowed));
    wait_flag("ping holdoff", F_LP, 1'b1, PH);
    fire(ERDY);
    @(negedge sys_clk);
    chk("lp after erdy", 16'h0000, 16'(lp_allowed));
    wait_flag("erdy holdoff", F_LP, 1'b1, EH);
    fire(ERDY);
    repeat (5) @(negedge sys_clk);
    fire(ESRV);
    repeat (3) @(negedge sys_clk);
    chk("lp after service", 16'h0001, 16'(lp_allowed));
  endtask

  task automatic t_wake();
    fire(WAKE);
    wait_flag("wake_resend", F_WAKE, 1'b1, WK + 1);
    fire(WAKE);
    fire(ACC);
    quiet("wake after access", F_WAKE, WK + 10);
  endtask

  task automatic t_ltm();
    logic [15:0] rq [5];
    rq = '{16'h0064, 16'h007C, 16'h007D, 16'h007E, 16'h0FA0};
    do_reset();
    repeat (2) @(negedge sys_clk);
    chk("send_ok idle", 16'h0001, 16'(ltm_send_ok));
    chk("ltm default", 16'h03E8, ltm_value);
    foreach (rq[k]) begin
      ltm_req_us = rq[k];
      fire(LREQ);
      chk("ltm_value", (rq[k] < 16'h007D) ? 16'h007D : rq[k], ltm_value);
    end
    fire(LSNT);
    chk("send_ok one sent", 16'h0001, 16'(ltm_send_ok));
    fire(LSNT);
    chk("send_ok two sent", 16'h0000, 16'(ltm_send_ok));
    wait_flag("slot free", F_OK, 1'b1, LW - 1);
    fire(LEN);
    @(negedge sys_clk);
    chk("notice owed", 16'h0001, 16'(ltm_notice_req));
    fire(LSNT);
    @(negedge sys_clk);
    chk("notice paid", 16'h0000, 16'(ltm_notice_req));
    fire(LEN);
    @(negedge sys_clk);
    wait_flag("ltm_notice_late", F_LTL, 1'b1, 400);
  endtask

  initial begin
    t_reset();
    t_ping();
    t_reply();
    t_gap();
    t_lp();
    t_wake();
    t_ltm();
    conclude();
  end
endmodule
